// ===== rtl/uahl_top.sv
// control and bulk list pointer registers with the list walker
// assumes same-clock inputs for enables, pending flags and frame marks
`default_nettype none
module uahl_top
    import uahl_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire uahl_reg_req_s reg_req,
    output logic [31:0] reg_rdata,
    input wire logic ctrl_list_walk_on,
    input wire logic bulk_list_walk_on,
    input wire logic ctrl_list_pending,
    input wire logic bulk_list_pending,
    output logic ctrl_list_pending_clr,
    output logic bulk_list_pending_clr,
    input wire logic frame_start,
    input wire logic frame_end,
    input wire logic init_start,
    input wire logic [31:0] shared_comm_area,
    output logic ed_serve_valid,
    output logic ed_serve_bulk,
    output logic [31:0] ed_serve_addr,
    input wire logic ed_serve_done,
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic walk_busy
);
    typedef enum logic [2:0] {ST_IDLE, ST_INIT, ST_PICK, ST_SERVE, ST_FETCH, ST_END}
        uahl_walk_e;

    uahl_walk_e state_reg;
    logic in_frame_reg;
    logic init_pend_reg;
    logic rr_bulk_reg;
    logic is_bulk_reg;
    logic [31:0] fetch_addr_reg;
    logic [31:0] rdata_reg;
    logic [31:0] ctrl_head;
    logic [31:0] ctrl_cur;
    logic [31:0] bulk_head;
    logic [31:0] bulk_cur;
    logic [31:0] sel_cur;
    logic pick_bulk;
    logic any_on;
    logic load_start;
    logic load_busy;
    logic load_ctrl_we;
    logic load_bulk_we;
    uahl_mem_req_s load_mem;
    logic adv_ctrl;
    logic adv_bulk;
    logic reload_ctrl;
    logic reload_bulk;
    logic sel_pending;

    function automatic logic hit(input uahl_reg_req_s r, input logic [31:0] ofs);
        hit = (r.addr == ofs);
    endfunction

    // register bus decode; software writes are taken in any walker state but lose to a hardware pointer update in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_reg <= RDATA_UNMAPPED;
        else if (reg_req.rd)
        begin
            if (hit(reg_req, OFS_CTRL_HEAD))
                rdata_reg <= ctrl_head;
            else if (hit(reg_req, OFS_CTRL_CUR))
                rdata_reg <= ctrl_cur;
            else if (hit(reg_req, OFS_BULK_HEAD))
                rdata_reg <= bulk_head;
            else if (hit(reg_req, OFS_BULK_CUR))
                rdata_reg <= bulk_cur;
            else
                rdata_reg <= RDATA_UNMAPPED;
        end
        else
            rdata_reg <= RDATA_UNMAPPED;
    end
    assign reg_rdata = rdata_reg;

    // frame window: a start in the same cycle as an end wins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            in_frame_reg <= 1'b0;
        else if (frame_start)
            in_frame_reg <= 1'b1;
        else if (frame_end)
            in_frame_reg <= 1'b0;
    end

    // an init request seen while walking is kept until idle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            init_pend_reg <= 1'b0;
        else if (init_start)
            init_pend_reg <= 1'b1;
        else if (load_start)
            init_pend_reg <= 1'b0;
    end

    assign any_on = ctrl_list_walk_on || bulk_list_walk_on;
    assign load_start = (state_reg == ST_IDLE) && init_pend_reg;
    // preferred list by turn, falling back to whichever is enabled
    assign pick_bulk = rr_bulk_reg ? bulk_list_walk_on : !ctrl_list_walk_on;
    assign sel_cur = is_bulk_reg ? bulk_cur : ctrl_cur;
    assign sel_pending = is_bulk_reg ? bulk_list_pending : ctrl_list_pending;

    // walking resumes from the stored current pointer, never the head
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_reg <= ST_IDLE;
        else
            unique case (state_reg)
                ST_IDLE:
                    if (load_start)
                        state_reg <= ST_INIT;
                    else if (in_frame_reg && any_on)
                        state_reg <= ST_PICK;
                ST_INIT:
                    if (!load_busy)
                        state_reg <= ST_IDLE;
                ST_PICK:
                    if (sel_cur == PTR_END)
                        state_reg <= ST_END;
                    else
                        state_reg <= ST_SERVE;
                ST_SERVE:
                    if (ed_serve_done)
                        state_reg <= ST_FETCH;
                ST_FETCH:
                    if (mem_ack)
                        state_reg <= ST_IDLE;
                ST_END:
                    state_reg <= ST_IDLE;
            endcase
    end

    // the list chosen for this pass is latched as the walker leaves idle, before the pick cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            is_bulk_reg <= 1'b0;
        else if (state_reg == ST_IDLE && !load_start && in_frame_reg && any_on)
            is_bulk_reg <= pick_bulk;
    end

    // turn flips after each pass so neither list starves
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rr_bulk_reg <= 1'b0;
        else if ((state_reg == ST_FETCH && mem_ack) || state_reg == ST_END)
            rr_bulk_reg <= !is_bulk_reg;
    end

    // next link sits in the fourth word of the descriptor
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            fetch_addr_reg <= PTR_RESET;
        else if (state_reg == ST_SERVE && ed_serve_done)
            fetch_addr_reg <= sel_cur + ED_NEXT_OFS;
    end

    assign adv_ctrl = (state_reg == ST_FETCH) && mem_ack && !is_bulk_reg;
    assign adv_bulk = (state_reg == ST_FETCH) && mem_ack && is_bulk_reg;
    assign reload_ctrl = (state_reg == ST_END) && !is_bulk_reg
        && ctrl_list_pending;
    assign reload_bulk = (state_reg == ST_END) && is_bulk_reg
        && bulk_list_pending;
    assign ctrl_list_pending_clr = reload_ctrl;
    assign bulk_list_pending_clr = reload_bulk;

    uahl_list_ptr u_ctrl (
        .clk(clk),
        .arst_n(arst_n),
        .sw_head_we(reg_req.wr && hit(reg_req, OFS_CTRL_HEAD)),
        .sw_cur_we(reg_req.wr && hit(reg_req, OFS_CTRL_CUR)),
        .sw_data(reg_req.wdata),
        .init_we(load_ctrl_we),
        .init_data(mem_rdata),
        .adv_we(adv_ctrl),
        .adv_data(mem_rdata),
        .reload(reload_ctrl),
        .head(ctrl_head),
        .cur(ctrl_cur)
    );

    uahl_list_ptr u_bulk (
        .clk(clk),
        .arst_n(arst_n),
        .sw_head_we(reg_req.wr && hit(reg_req, OFS_BULK_HEAD)),
        .sw_cur_we(reg_req.wr && hit(reg_req, OFS_BULK_CUR)),
        .sw_data(reg_req.wdata),
        .init_we(load_bulk_we),
        .init_data(mem_rdata),
        .adv_we(adv_bulk),
        .adv_data(mem_rdata),
        .reload(reload_bulk),
        .head(bulk_head),
        .cur(bulk_cur)
    );

    uahl_init_loader u_load (
        .clk(clk),
        .arst_n(arst_n),
        .start(load_start),
        .shared_comm_area(shared_comm_area),
        .mem_out(load_mem),
        .mem_ack(mem_ack && state_reg == ST_INIT),
        .mem_rdata(mem_rdata),
        .ctrl_we(load_ctrl_we),
        .bulk_we(load_bulk_we),
        .busy(load_busy)
    );

    // the loader owns the memory port only while initialising
    assign mem_req = (state_reg == ST_INIT) ? load_mem.req : (state_reg == ST_FETCH);
    assign mem_addr = (state_reg == ST_INIT) ? load_mem.addr : fetch_addr_reg;
    assign ed_serve_valid = (state_reg == ST_SERVE);
    assign ed_serve_bulk = is_bulk_reg;
    assign ed_serve_addr = sel_cur;
    assign walk_busy = (state_reg != ST_IDLE);

    sequence s_ctrl_fetch;
        state_reg == ST_FETCH && mem_ack && !is_bulk_reg;
    endsequence
    sequence s_bulk_fetch;
        state_reg == ST_FETCH && mem_ack && is_bulk_reg;
    endsequence
    sequence s_ctrl_end;
        state_reg == ST_END && !is_bulk_reg;
    endsequence
    sequence s_bulk_end;
        state_reg == ST_END && is_bulk_reg;
    endsequence

    property p_serve_ctrl_addr;
        @(posedge clk) disable iff (!arst_n)
        ed_serve_valid && !ed_serve_bulk |-> ed_serve_addr == ctrl_cur && ctrl_cur != PTR_END;
    endproperty
    a_serve_ctrl_addr: assert property (p_serve_ctrl_addr)
        else $error("control service not at control current pointer");

    property p_serve_bulk_addr;
        @(posedge clk) disable iff (!arst_n)
        ed_serve_valid && ed_serve_bulk |-> ed_serve_addr == bulk_cur && bulk_cur != PTR_END;
    endproperty
    a_serve_bulk_addr: assert property (p_serve_bulk_addr)
        else $error("bulk service not at bulk current pointer");

    property p_ctrl_advance;
        @(posedge clk) disable iff (!arst_n)
        s_ctrl_fetch |=> ctrl_cur == ($past(mem_rdata) & PTR_MASK);
    endproperty
    a_ctrl_advance: assert property (p_ctrl_advance)
        else $error("control current did not take the next link");

    property p_bulk_advance;
        @(posedge clk) disable iff (!arst_n)
        s_bulk_fetch |=> bulk_cur == ($past(mem_rdata) & PTR_MASK) && $stable(ctrl_cur);
    endproperty
    a_bulk_advance: assert property (p_bulk_advance)
        else $error("bulk current did not take the next link");

    property p_ctrl_reload;
        @(posedge clk) disable iff (!arst_n)
        s_ctrl_end ##0 ctrl_list_pending |->
            ctrl_list_pending_clr ##1 ctrl_cur == $past(ctrl_head);
    endproperty
    a_ctrl_reload: assert property (p_ctrl_reload)
        else $error("control end with pending did not reload");

    property p_ctrl_idle_end;
        @(posedge clk) disable iff (!arst_n)
        s_ctrl_end ##0 !ctrl_list_pending && !reg_req.wr |->
            !ctrl_list_pending_clr ##1 $stable(ctrl_cur);
    endproperty
    a_ctrl_idle_end: assert property (p_ctrl_idle_end)
        else $error("control end without pending changed state");

    property p_bulk_reload;
        @(posedge clk) disable iff (!arst_n)
        s_bulk_end ##0 bulk_list_pending |->
            bulk_list_pending_clr ##1 bulk_cur == $past(bulk_head);
    endproperty
    a_bulk_reload: assert property (p_bulk_reload)
        else $error("bulk end with pending did not reload");

    property p_bulk_idle_end;
        @(posedge clk) disable iff (!arst_n)
        s_bulk_end ##0 !bulk_list_pending && !reg_req.wr |->
            !bulk_list_pending_clr ##1 $stable(bulk_cur);
    endproperty
    a_bulk_idle_end: assert property (p_bulk_idle_end)
        else $error("bulk end without pending changed state");

    property p_zero_is_end;
        @(posedge clk) disable iff (!arst_n)
        state_reg == ST_PICK && sel_cur == PTR_END |=> state_reg == ST_END;
    endproperty
    a_zero_is_end: assert property (p_zero_is_end)
        else $error("zero link not treated as end of list");

    property p_frame_resume;
        @(posedge clk) disable iff (!arst_n)
        frame_start && state_reg == ST_IDLE && !reg_req.wr |=>
            $stable(ctrl_cur) && $stable(bulk_cur);
    endproperty
    a_frame_resume: assert property (p_frame_resume)
        else $error("frame start moved a current pointer");

    property p_round_robin;
        @(posedge clk) disable iff (!arst_n)
        state_reg == ST_FETCH && mem_ack |=> rr_bulk_reg == !$past(is_bulk_reg);
    endproperty
    a_round_robin: assert property (p_round_robin)
        else $error("turn did not pass after a service");
endmodule
`default_nettype wire

// ===== include/uahl_pkg.sv
// constants and carrier types for the control/bulk list pointer block
// assumes a single 100 MHz system clock and 32-bit byte addresses
`default_nettype none
package uahl_pkg;
    localparam logic [31:0] OFS_CTRL_HEAD = 32'h9010_1020;
    localparam logic [31:0] OFS_CTRL_CUR = 32'h9010_1024;
    localparam logic [31:0] OFS_BULK_HEAD = 32'h9010_1028;
    localparam logic [31:0] OFS_BULK_CUR = 32'h9010_102C;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [31:0] PTR_MASK = 32'hFFFF_FFF0;
    localparam logic [31:0] PTR_END = 32'h0000_0000;
    localparam logic [31:0] ED_NEXT_OFS = 32'h0000_000C;
    localparam logic [31:0] COMM_ALIGN_MASK = 32'hFFFF_FF00;
    localparam logic [31:0] COMM_CTRL_HEAD_OFS = 32'h0000_0080;
    localparam logic [31:0] COMM_BULK_HEAD_OFS = 32'h0000_0084;
    localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } uahl_reg_req_s;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } uahl_mem_req_s;
endpackage
`default_nettype wire

// ===== rtl/uahl_list_ptr.sv
// head and current pointer pair for one list
// assumes all strobes come from logic on the same clock
`default_nettype none
module uahl_list_ptr
    import uahl_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic sw_head_we,
    input wire logic sw_cur_we,
    input wire logic [31:0] sw_data,
    input wire logic init_we,
    input wire logic [31:0] init_data,
    input wire logic adv_we,
    input wire logic [31:0] adv_data,
    input wire logic reload,
    output logic [31:0] head,
    output logic [31:0] cur
);
    logic [31:0] head_reg;
    logic [31:0] cur_reg;

    // init load wins over a software write in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            head_reg <= PTR_RESET;
        else if (init_we)
            head_reg <= init_data & PTR_MASK;
        else if (sw_head_we)
            head_reg <= sw_data & PTR_MASK;
    end

    // hardware walk updates win over a software write
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            cur_reg <= PTR_RESET;
        else if (reload)
            cur_reg <= head_reg;
        else if (adv_we)
            cur_reg <= adv_data & PTR_MASK;
        else if (sw_cur_we)
            cur_reg <= sw_data & PTR_MASK;
    end

    assign head = head_reg;
    assign cur = cur_reg;

    property p_low_bits_clear;
        @(posedge clk) disable iff (!arst_n)
        (head_reg[3:0] == 4'h0) && (cur_reg[3:0] == 4'h0);
    endproperty
    a_low_bits_clear: assert property (p_low_bits_clear)
        else $error("pointer low bits not zero");
endmodule
`default_nettype wire

// ===== rtl/uahl_init_loader.sv
// fetches both list heads from the shared communication area
// assumes the memory port answers each request with a one-cycle ack
`default_nettype none
module uahl_init_loader
    import uahl_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [31:0] shared_comm_area,
    output uahl_mem_req_s mem_out,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic ctrl_we,
    output logic bulk_we,
    output logic busy
);
    typedef enum logic [1:0] {L_IDLE, L_CTRL, L_BULK} uahl_load_e;
    uahl_load_e state_reg;
    logic [31:0] addr_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            state_reg <= L_IDLE;
        else
            unique case (state_reg)
                L_IDLE: if (start) state_reg <= L_CTRL;
                L_CTRL: if (mem_ack) state_reg <= L_BULK;
                L_BULK: if (mem_ack) state_reg <= L_IDLE;
            endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            addr_reg <= PTR_RESET;
        else if (state_reg == L_IDLE && start)
            addr_reg <= (shared_comm_area & COMM_ALIGN_MASK) + COMM_CTRL_HEAD_OFS;
        else if (state_reg == L_CTRL && mem_ack)
            addr_reg <= (shared_comm_area & COMM_ALIGN_MASK) + COMM_BULK_HEAD_OFS;
    end

    assign mem_out.req = (state_reg != L_IDLE);
    assign mem_out.addr = addr_reg;
    assign ctrl_we = (state_reg == L_CTRL) && mem_ack;
    assign bulk_we = (state_reg == L_BULK) && mem_ack;
    assign busy = (state_reg != L_IDLE);

    sequence s_load_seq;
        start && state_reg == L_IDLE ##1 mem_out.req;
    endsequence
    property p_load_starts;
        @(posedge clk) disable iff (!arst_n)
        s_load_seq |-> mem_out.addr[7:0] == COMM_CTRL_HEAD_OFS[7:0];
    endproperty
    a_load_starts: assert property (p_load_starts)
        else $error("init load not aimed at control head slot");
endmodule
`default_nettype wire

// ===== verification/uahl_mem_model.sv
// partner: descriptor memory and transfer engine facing the list walker
// assumes the walker ports of uahl_top on the same clock; lat sets answer delay
`default_nettype none
module uahl_mem_model
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] lat,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    input wire logic ed_serve_valid,
    output logic ed_serve_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] mem_cnt;
    logic [3:0] srv_cnt;

    // comm area at 0x3000; links at descriptor + 0xC; zero link ends a list
    function automatic logic [31:0] word_at(input logic [31:0] a);
        case (a)
            32'h0000_3080: return 32'h0000_1000;
            32'h0000_3084: return 32'h0000_2000;
            32'h0000_100C: return 32'h0000_1100;
            32'h0000_200C: return 32'h0000_2100;
            32'h0000_210C: return 32'h0000_2200;
            default: return 32'h0000_0000;
        endcase
    endfunction

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_cnt <= 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
        end
        else if (mem_req && !mem_ack && mem_cnt >= lat)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= word_at(mem_addr);
            mem_cnt <= 4'h0;
        end
        else
        begin
            mem_ack <= 1'b0;
            // released data keeps toggling so a stale word never looks valid
            mem_rdata <= ~mem_rdata;
            mem_cnt <= mem_req ? mem_cnt + 4'h1 : 4'h0;
        end
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            srv_cnt <= 4'h0;
            ed_serve_done <= 1'b0;
        end
        else
        begin
            ed_serve_done <= ed_serve_valid && !ed_serve_done && srv_cnt >= lat;
            srv_cnt <= (ed_serve_valid && !ed_serve_done) ? srv_cnt + 4'h1 : 4'h0;
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb_usb_host_async_list_pointers.sv
// self-checking bench for the list pointer block
// assumes uahl_mem_model as memory and transfer engine; flags held here
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module tb_usb_host_async_list_pointers
    import uahl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [31:0] addr; logic [31:0] wdata; logic [31:0] exp;} uahl_row_s;
    localparam uahl_row_s ROWS [0:4] = '{
        '{OFS_CTRL_HEAD, 32'h1234_5678, 32'h1234_5670},
        '{OFS_CTRL_CUR, 32'hA5A5_A5A0, 32'hA5A5_A5A0},
        '{OFS_BULK_HEAD, 32'h0F0F_0F0F, 32'h0F0F_0F00},
        '{OFS_BULK_CUR, 32'hFFFF_FFFF, 32'hFFFF_FFF0},
        '{32'h9010_1030, 32'h5555_5555, RDATA_UNMAPPED}
    };
    logic clk, arst_n, c_on, b_on, c_pend, b_pend, c_clr, b_clr, f_start, f_end, init_start;
    logic s_valid, s_bulk, s_done, mem_req, mem_ack, busy;
    logic [31:0] rdata, comm, s_addr, mem_addr, mem_rdata, rv;
    logic [3:0] lat;
    uahl_reg_req_s reg_req;
    logic [32:0] served[$];
    int n_mismatch, n_checks, n_cclr, n_bclr;

    uahl_top u_dut (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(rdata),
        .ctrl_list_walk_on(c_on), .bulk_list_walk_on(b_on), .ctrl_list_pending(c_pend),
        .bulk_list_pending(b_pend), .ctrl_list_pending_clr(c_clr),
        .bulk_list_pending_clr(b_clr), .frame_start(f_start), .frame_end(f_end),
        .init_start(init_start), .shared_comm_area(comm), .ed_serve_valid(s_valid),
        .ed_serve_bulk(s_bulk), .ed_serve_addr(s_addr), .ed_serve_done(s_done),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .walk_busy(busy));
    uahl_mem_model u_mem (.clk(clk), .arst_n(arst_n), .lat(lat), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .ed_serve_valid(s_valid), .ed_serve_done(s_done));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // flags live outside the block; a clear pulse drops them
    always @(posedge clk)
    begin
        if (s_valid && s_done)
            served.push_back({s_bulk, s_addr});
        if (arst_n && c_clr)
        begin
            c_pend <= 1'b0;
            n_cclr++;
        end
        if (arst_n && b_clr)
        begin
            b_pend <= 1'b0;
            n_bclr++;
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        reg_req <= '0;
        #1 d = rdata;
    endtask

    task automatic pulse_frame(input logic is_end);
        @(posedge clk);
        if (is_end)
            f_end <= 1'b1;
        else
            f_start <= 1'b1;
        @(posedge clk);
        f_end <= 1'b0;
        f_start <= 1'b0;
    endtask

    // bounded waits; running out counts as a mismatch and ends the run
    task automatic wait_until(input int what, input int n);
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(posedge clk);
            #1;
            if ((what == 0 && busy === 1'b0) || (what == 1 && busy === 1'b1)
                || (what == 2 && served.size() >= n))
                return;
        end
        n_mismatch++;
        $display("MISMATCH t=%0t wait ran out", $time);
        conclude();
    endtask

    initial
    begin
        arst_n = 1'b0;
        reg_req = '0;
        {c_on, b_on, c_pend, b_pend, f_start, f_end, init_start} = 7'h00;
        comm = 32'h0;
        lat = 4'h0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFS_CTRL_CUR, rv);
        `CHK(rv, PTR_RESET)
        rd(OFS_BULK_CUR, rv);
        `CHK(rv, PTR_RESET)
        for (int i = 0; i < 5; i++)
        begin
            wr(ROWS[i].addr, ROWS[i].wdata);
            rd(ROWS[i].addr, rv);
            `CHK(rv, ROWS[i].exp)
        end
        wr(OFS_CTRL_CUR, PTR_END);
        wr(OFS_BULK_CUR, PTR_END);
        // low byte of the base must be ignored
        comm <= 32'h0000_30A5;
        @(posedge clk);
        init_start <= 1'b1;
        @(posedge clk);
        init_start <= 1'b0;
        wait_until(1, 0);
        wait_until(0, 0);
        rd(OFS_CTRL_HEAD, rv);
        `CHK(rv, 32'h0000_1000)
        rd(OFS_BULK_HEAD, rv);
        `CHK(rv, 32'h0000_2000)
        c_pend <= 1'b1;
        c_on <= 1'b1;
        pulse_frame(1'b0);
        wait_until(2, 2);
        pulse_frame(1'b1);
        wait_until(0, 0);
        c_on <= 1'b0;
        `CHK(served[0], 33'h0_0000_1000)
        `CHK(served[1], 33'h0_0000_1100)
        `CHK(c_pend, 1'b0)
        `CHK(n_cclr, 1)
        rd(OFS_CTRL_CUR, rv);
        `CHK(rv, PTR_END)
        // slow partner; frame closes during the link fetch after the first bulk service
        lat <= 4'h3;
        served.delete();
        b_pend <= 1'b1;
        b_on <= 1'b1;
        pulse_frame(1'b0);
        wait_until(2, 1);
        pulse_frame(1'b1);
        wait_until(0, 0);
        `CHK(served.size(), 1)
        `CHK(served[0], 33'h1_0000_2000)
        `CHK(b_pend, 1'b0)
        rd(OFS_BULK_CUR, rv);
        `CHK(rv, 32'h0000_2100)
        served.delete();
        pulse_frame(1'b0);
        wait_until(2, 2);
        pulse_frame(1'b1);
        wait_until(0, 0);
        `CHK(served[0], 33'h1_0000_2100)
        `CHK(served[1], 33'h1_0000_2200)
        `CHK(n_bclr, 1)
        rd(OFS_BULK_CUR, rv);
        `CHK(rv, PTR_END)
        // both lists on: turns alternate, control first after a bulk pass
        b_on <= 1'b0;
        wr(OFS_CTRL_CUR, 32'h0000_1100);
        wr(OFS_BULK_CUR, 32'h0000_2200);
        served.delete();
        c_on <= 1'b1;
        b_on <= 1'b1;
        pulse_frame(1'b0);
        wait_until(2, 2);
        pulse_frame(1'b1);
        wait_until(0, 0);
        `CHK(served[0], 33'h0_0000_1100)
        `CHK(served[1], 33'h1_0000_2200)
        // reset in mid-run must drop pointers that software had set
        c_on <= 1'b0;
        b_on <= 1'b0;
        wr(OFS_CTRL_CUR, 32'h0000_1100);
        wr(OFS_BULK_CUR, 32'h0000_2200);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFS_CTRL_CUR, rv);
        `CHK(rv, PTR_RESET)
        rd(OFS_BULK_CUR, rv);
        `CHK(rv, PTR_RESET)
        conclude();
    end
endmodule
`default_nettype wire
